// ==== logic/usbip_consts.svh ====
// constants for the indirect usb register port
`ifndef USBIP_CONSTS_SVH
`define USBIP_CONSTS_SVH
`define USBIP_SFR_ADDR_REG 8'h96
`define USBIP_SFR_DATA_REG 8'h97
`define USBIP_BUSY_BIT 7
`define USBIP_AUTO_BIT 6
`define USBIP_SEL_MSB 5
`define USBIP_DATA_RESET 8'h00
`define USBIP_SEL_RESET 6'h00
`define USBIP_FUNC_ADDR 6'h00
`define USBIP_POWER 6'h01
`define USBIP_IN_IRQ_FLAGS 6'h02
`define USBIP_OUT_IRQ_FLAGS 6'h04
`define USBIP_COMMON_IRQ_FLAGS 6'h06
`define USBIP_IN_IRQ_EN 6'h07
`define USBIP_OUT_IRQ_EN 6'h09
`define USBIP_COMMON_IRQ_EN 6'h0b
`define USBIP_FRAME_LOW 6'h0c
`define USBIP_FRAME_HIGH 6'h0d
`define USBIP_EP_SELECT 6'h0e
`define USBIP_CLK_RECOVERY 6'h0f
`define USBIP_EP0_CSR 6'h11
`define USBIP_IN_CSR_HIGH 6'h12
`define USBIP_OUT_CSR_LOW 6'h14
`define USBIP_OUT_CSR_HIGH 6'h15
`define USBIP_EP0_RX_COUNT 6'h16
`define USBIP_OUT_COUNT_HIGH 6'h17
`define USBIP_EP_ENABLE 6'h1e
`define USBIP_FIFO_BASE 4'h8
`define USBIP_CLK_RECOVERY_RESET 8'h0f
`define USBIP_REG_RESET 8'h00
`define USBIP_EP_SEL_WIDTH 4
`define USBIP_FUNC_ADDR_WIDTH 7
`endif

// ==== logic/usbip_pkg.sv ====
// types shared by the indirect usb register port
package usbip_pkg;
	typedef enum logic [2:0] {
		USBIP_IDLE = 3'b001,
		USBIP_FETCH = 3'b010,
		USBIP_CAPTURE = 3'b100
	} usbip_state_t;
	typedef logic [5:0] usbip_core_addr_t;
	typedef logic [7:0] usbip_byte_t;
endpackage

// ==== logic/usbip_mem_if.sv ====
// carrier between the port controller and the indexed register memory
interface usbip_mem_if #(parameter int AW = 4);
	logic wr;
	logic [AW-1:0] waddr;
	logic [7:0] wdata;
	logic rd;
	logic [AW-1:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output wr, output waddr, output wdata, output rd, output raddr, input rdata);
	modport mem (input wr, input waddr, input wdata, input rd, input raddr, output rdata);
endinterface

// ==== logic/usbip_ep_mem.sv ====
// per-endpoint indexed control/status storage, registered read
module usbip_ep_mem #(parameter int AW = 4)
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	usbip_mem_if.mem bus
);
	logic [7:0] store_q [0:(1<<AW)-1];
	logic [7:0] rdata_q;
	always_ff @(posedge core_clk_in)
	begin
		if (bus.wr)
			store_q[bus.waddr] <= bus.wdata;
	end
	// reset only the read port; contents are cleared by software setup
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else if (bus.rd)
			rdata_q <= store_q[bus.raddr];
	end
	assign bus.rdata = rdata_q;
endmodule

// ==== logic/usbip_flag_bank.sv ====
// sticky event flags, cleared when fetched through the port
module usbip_flag_bank #(parameter int W = 8)
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] event_in,
	input wire logic clear_in,
	output logic [W-1:0] flags_out
);
	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;
	// a new event in the clearing cycle survives
	assign flags_d = (clear_in ? {W{1'b0}} : flags_q) | event_in;
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			flags_q <= {W{1'b0}};
		else
			flags_q <= flags_d;
	end
	assign flags_out = flags_q;
endmodule

// ==== logic/usbip_top.sv ====
// indirect register port into the usb function controller core
`include "usbip_consts.svh"

// Behaviour
// [RL1] data port register at sfr 0x97, resets to zero, carries all core traffic
// [RL2] writing the data port forwards the byte to the selected core register
// [RL3] repeated data writes go to the same selection without reselecting
// [RL4] writing one to busy starts a fetch of the selected core register
// [RL5] selection and fetch start accepted together in one address write
// [RL6] busy stays high during a fetch; data valid once busy clears
// [RL7] refetch of same register needs only a new busy write
// [RL8] with auto fetch set, reading the data port starts the next fetch
// [RL9] software keeps the usb clock running during indirect accesses
// [RL10] core addresses 0x02, 0x04, 0x06 hold the three interrupt flag groups
// [RL11] core addresses 0x07, 0x09, 0x0b hold the three interrupt enable groups
// [RL12] function address at 0x00, frame number at 0x0c and 0x0d
// [RL13] indexed registers act on the endpoint chosen by select at 0x0e
// [RL14] out control/status low and high at 0x14 and 0x15, indexed
// [RL15] endpoint-0 receive count at 0x16, out packet count high at 0x17
// [RL16] unassigned core addresses read zero and ignore writes
module usbip_top
	import usbip_pkg::*;
#(
	parameter int EP_COUNT = 4,
	parameter int EP_AW = 2
)
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic [7:0] in_irq_event_in,
	input wire logic [7:0] out_irq_event_in,
	input wire logic [7:0] common_irq_event_in,
	input wire logic [7:0] frame_number_low_in,
	input wire logic [7:0] frame_number_high_in,
	input wire logic [7:0] endpoint0_rx_count_in,
	input wire logic [7:0] out_packet_count_high_in,
	input wire logic [7:0] fifo_rdata_in,
	output logic [6:0] function_address_out,
	output logic [7:0] power_management_out,
	output logic [7:0] in_endpoint_irq_enables_out,
	output logic [7:0] out_endpoint_irq_enables_out,
	output logic [7:0] common_irq_enables_out,
	output logic [3:0] endpoint_select_out,
	output logic [7:0] clock_recovery_control_out,
	output logic [7:0] endpoint_enable_out,
	output logic [7:0] in_endpoint_irq_flags_out,
	output logic [7:0] out_endpoint_irq_flags_out,
	output logic [7:0] common_irq_flags_out,
	output logic fifo_wr_out,
	output logic fifo_rd_out,
	output logic [1:0] fifo_sel_out,
	output logic [7:0] fifo_wdata_out,
	output logic busy_out
);
	// true for the indexed control/status group
	function automatic logic is_indexed(input usbip_core_addr_t a);
		is_indexed = (a == `USBIP_EP0_CSR) || (a == `USBIP_IN_CSR_HIGH) ||
			(a == `USBIP_OUT_CSR_LOW) || (a == `USBIP_OUT_CSR_HIGH);
	endfunction

	// packs endpoint and register slot into a memory address
	function automatic logic [EP_AW+1:0] slot_addr(input logic [3:0] ep,
		input usbip_core_addr_t a);
		logic [1:0] slot;
		slot = (a == `USBIP_EP0_CSR) ? 2'd0 :
			(a == `USBIP_IN_CSR_HIGH) ? 2'd1 :
			(a == `USBIP_OUT_CSR_LOW) ? 2'd2 : 2'd3;
		slot_addr = {ep[EP_AW-1:0], slot};
	endfunction

	// true for the four endpoint fifo windows
	function automatic logic is_fifo(input usbip_core_addr_t a);
		is_fifo = (a[5:2] == `USBIP_FIFO_BASE);
	endfunction

	usbip_state_t state_q, state_d;
	usbip_core_addr_t sel_q, sel_d;
	logic auto_q, auto_d;
	logic busy_q, busy_d;
	logic [7:0] data_q, data_d;
	logic [7:0] rdata_q, rdata_d;
	logic [6:0] func_addr_q;
	logic [7:0] power_q;
	logic [7:0] in_en_q;
	logic [7:0] out_en_q;
	logic [7:0] common_en_q;
	logic [3:0] ep_sel_q;
	logic [7:0] clk_rec_q;
	logic [7:0] ep_en_q;
	logic fifo_wr_q;
	logic fifo_rd_q;
	logic [1:0] fifo_sel_q;
	logic [7:0] fifo_wdata_q;
	logic [7:0] in_flags;
	logic [7:0] out_flags;
	logic [7:0] common_flags;
	logic [7:0] core_rdata;

	usbip_mem_if #(.AW(EP_AW + 2)) mem_bus ();

	// sfr decode
	wire adr_hit = (sfr_addr_in == `USBIP_SFR_ADDR_REG);
	wire dat_hit = (sfr_addr_in == `USBIP_SFR_DATA_REG);
	wire adr_wr = sfr_wr_in && adr_hit;
	wire dat_wr = sfr_wr_in && dat_hit;
	wire dat_rd = sfr_rd_in && dat_hit;

	// fetch request sources
	wire manual_start = adr_wr && sfr_wdata_in[`USBIP_BUSY_BIT]; // RL4 RL7
	wire auto_start = dat_rd && auto_q && !busy_q; // RL8
	wire fetch_start = (state_q == USBIP_IDLE) && (manual_start || auto_start);
	// a start while busy is dropped; the selection still moves

	// selected endpoint must exist for indexed traffic
	wire ep_valid = (ep_sel_q < EP_COUNT);
	// without this guard a reserved endpoint would alias a real one
	wire core_wr = dat_wr; // RL2 RL3
	wire idx_wr = core_wr && is_indexed(sel_q) && ep_valid; // RL13
	wire wr_hit_func = core_wr && (sel_q == `USBIP_FUNC_ADDR);
	wire wr_hit_power = core_wr && (sel_q == `USBIP_POWER);
	wire wr_hit_in_en = core_wr && (sel_q == `USBIP_IN_IRQ_EN);
	wire wr_hit_out_en = core_wr && (sel_q == `USBIP_OUT_IRQ_EN);
	wire wr_hit_cm_en = core_wr && (sel_q == `USBIP_COMMON_IRQ_EN);
	wire wr_hit_ep_sel = core_wr && (sel_q == `USBIP_EP_SELECT);
	wire wr_hit_clk = core_wr && (sel_q == `USBIP_CLK_RECOVERY);
	wire wr_hit_ep_en = core_wr && (sel_q == `USBIP_EP_ENABLE);
	wire wr_hit_fifo = core_wr && is_fifo(sel_q);

	// capture-cycle qualifiers; flags clear only when really read
	wire capturing = (state_q == USBIP_CAPTURE);
	wire clr_in_flags = capturing && (sel_q == `USBIP_IN_IRQ_FLAGS);
	wire clr_out_flags = capturing && (sel_q == `USBIP_OUT_IRQ_FLAGS);
	wire clr_cm_flags = capturing && (sel_q == `USBIP_COMMON_IRQ_FLAGS);

	// indexed memory port
	assign mem_bus.wr = idx_wr;
	assign mem_bus.waddr = slot_addr(ep_sel_q, sel_q);
	assign mem_bus.wdata = sfr_wdata_in;
	// read port runs one cycle ahead of the capture
	assign mem_bus.rd = (state_q == USBIP_FETCH);
	assign mem_bus.raddr = slot_addr(ep_sel_q, sel_q);

	usbip_ep_mem #(.AW(EP_AW + 2)) u_ep_mem (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.bus(mem_bus.mem)
	);

	// one sticky bank per interrupt group
	usbip_flag_bank #(.W(8)) u_in_flags (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.event_in(in_irq_event_in),
		.clear_in(clr_in_flags),
		.flags_out(in_flags)
	);

	usbip_flag_bank #(.W(8)) u_out_flags (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.event_in(out_irq_event_in),
		.clear_in(clr_out_flags),
		.flags_out(out_flags)
	);

	usbip_flag_bank #(.W(8)) u_common_flags (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.event_in(common_irq_event_in),
		.clear_in(clr_cm_flags),
		.flags_out(common_flags)
	);

	// core register read selection
	always_comb
	begin
		core_rdata = 8'h00; // RL16
		case (sel_q)
			`USBIP_FUNC_ADDR: core_rdata = {1'b0, func_addr_q}; // RL12
			`USBIP_POWER: core_rdata = power_q;
			`USBIP_IN_IRQ_FLAGS: core_rdata = in_flags; // RL10
			`USBIP_OUT_IRQ_FLAGS: core_rdata = out_flags; // RL10
			`USBIP_COMMON_IRQ_FLAGS: core_rdata = common_flags; // RL10
			`USBIP_IN_IRQ_EN: core_rdata = in_en_q; // RL11
			`USBIP_OUT_IRQ_EN: core_rdata = out_en_q; // RL11
			`USBIP_COMMON_IRQ_EN: core_rdata = common_en_q; // RL11
			`USBIP_FRAME_LOW: core_rdata = frame_number_low_in; // RL12
			`USBIP_FRAME_HIGH: core_rdata = frame_number_high_in; // RL12
			`USBIP_EP_SELECT: core_rdata = {4'h0, ep_sel_q};
			`USBIP_CLK_RECOVERY: core_rdata = clk_rec_q;
			`USBIP_EP_ENABLE: core_rdata = ep_en_q;
			`USBIP_EP0_RX_COUNT: core_rdata = endpoint0_rx_count_in; // RL15
			`USBIP_OUT_COUNT_HIGH: core_rdata = out_packet_count_high_in; // RL15
			default:
			begin
				if (is_indexed(sel_q) && ep_valid)
					core_rdata = mem_bus.rdata; // RL13 RL14
				else if (is_fifo(sel_q))
					core_rdata = fifo_rdata_in;
				else
					core_rdata = 8'h00; // RL16
			end
		endcase
	end

	// fetch sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			USBIP_IDLE:
			begin
				if (fetch_start)
					state_d = USBIP_FETCH;
			end
			USBIP_FETCH: state_d = USBIP_CAPTURE;
			USBIP_CAPTURE: state_d = USBIP_IDLE;
			default: state_d = USBIP_IDLE;
		endcase
	end

	// address register: selection and start may land in the same write
	assign sel_d = adr_wr ? sfr_wdata_in[`USBIP_SEL_MSB:0] : sel_q; // RL5
	assign auto_d = adr_wr ? sfr_wdata_in[`USBIP_AUTO_BIT] : auto_q;
	// writing zero to busy never cancels a fetch
	assign busy_d = fetch_start ? 1'b1 : (capturing ? 1'b0 : busy_q); // RL6

	// data port: software writes win over nothing, fetch result lands at capture
	assign data_d = capturing ? core_rdata : (dat_wr ? sfr_wdata_in : data_q); // RL1 RL6

	// sfr read data, registered
	// any other sfr address reads zero
	assign rdata_d = !sfr_rd_in ? rdata_q :
		adr_hit ? {busy_q, auto_q, sel_q} :
		dat_hit ? data_q : 8'h00;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_q <= USBIP_IDLE;
			sel_q <= `USBIP_SEL_RESET;
			auto_q <= 1'b0;
			busy_q <= 1'b0;
			data_q <= `USBIP_DATA_RESET; // RL1
			rdata_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			sel_q <= sel_d;
			auto_q <= auto_d;
			busy_q <= busy_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
		end
	end

	// common core registers, written through the data port
	// reserved bits of these bytes are stored as written, except function address keeps 7 bits and endpoint select keeps 4
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			func_addr_q <= 7'h00;
			power_q <= `USBIP_REG_RESET;
			in_en_q <= `USBIP_REG_RESET;
			out_en_q <= `USBIP_REG_RESET;
			common_en_q <= `USBIP_REG_RESET;
			ep_sel_q <= 4'h0;
			clk_rec_q <= `USBIP_CLK_RECOVERY_RESET;
			ep_en_q <= `USBIP_REG_RESET;
		end
		else
		begin
			if (wr_hit_func)
				func_addr_q <= sfr_wdata_in[`USBIP_FUNC_ADDR_WIDTH-1:0]; // RL12
			if (wr_hit_power)
				power_q <= sfr_wdata_in;
			if (wr_hit_in_en)
				in_en_q <= sfr_wdata_in; // RL11
			if (wr_hit_out_en)
				out_en_q <= sfr_wdata_in; // RL11
			if (wr_hit_cm_en)
				common_en_q <= sfr_wdata_in; // RL11
			if (wr_hit_ep_sel)
				ep_sel_q <= sfr_wdata_in[`USBIP_EP_SEL_WIDTH-1:0]; // RL13
			if (wr_hit_clk)
				clk_rec_q <= sfr_wdata_in;
			if (wr_hit_ep_en)
				ep_en_q <= sfr_wdata_in;
		end
	end

	// fifo strobes toward the buffer memory, one cycle each
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			fifo_wr_q <= 1'b0;
			fifo_rd_q <= 1'b0;
			fifo_sel_q <= 2'b00;
			fifo_wdata_q <= 8'h00;
		end
		else
		begin
			fifo_wr_q <= wr_hit_fifo; // RL2
			// fifo byte must arrive in the capture cycle
			fifo_rd_q <= fetch_start && is_fifo(sel_d);
			if (wr_hit_fifo)
			begin
				fifo_sel_q <= sel_q[1:0];
				fifo_wdata_q <= sfr_wdata_in;
			end
			else if (fetch_start)
				fifo_sel_q <= sel_d[1:0];
		end
	end

	// every output is a register copy
	assign sfr_rdata_out = rdata_q;
	assign busy_out = busy_q;
	assign function_address_out = func_addr_q;
	assign power_management_out = power_q;
	assign in_endpoint_irq_enables_out = in_en_q;
	assign out_endpoint_irq_enables_out = out_en_q;
	assign common_irq_enables_out = common_en_q;
	assign endpoint_select_out = ep_sel_q;
	assign clock_recovery_control_out = clk_rec_q;
	assign endpoint_enable_out = ep_en_q;
	assign in_endpoint_irq_flags_out = in_flags;
	assign out_endpoint_irq_flags_out = out_flags;
	assign common_irq_flags_out = common_flags;
	assign fifo_wr_out = fifo_wr_q;
	assign fifo_rd_out = fifo_rd_q;
	assign fifo_sel_out = fifo_sel_q;
	assign fifo_wdata_out = fifo_wdata_q;
endmodule

// ==== test/usbip_top_asserts.sv ====
// pin-level assertions for the indirect usb register port
module usbip_top_asserts #(parameter int EP_COUNT = 4)
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [6:0] function_address_out,
	input wire logic [7:0] power_management_out,
	input wire logic [7:0] in_endpoint_irq_enables_out,
	input wire logic [3:0] endpoint_select_out,
	input wire logic [7:0] clock_recovery_control_out,
	input wire logic fifo_rd_out,
	input wire logic [1:0] fifo_sel_out,
	input wire logic busy_out
);
	logic [5:0] sel_q;
	logic auto_q;
	wire wa = sfr_wr_in && sfr_addr_in == 8'h96;
	wire wd = sfr_wr_in && sfr_addr_in == 8'h97 && !busy_out;
	wire rdd = sfr_rd_in && sfr_addr_in == 8'h97 && !busy_out;
	// shadow of selection and auto flag, seen only through the pins
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			{auto_q, sel_q} <= 7'h00;
		else if (wa)
			{auto_q, sel_q} <= sfr_wdata_in[6:0];
	end
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	property p_start;
		wa && sfr_wdata_in[7] && !busy_out |-> ##[1:2] busy_out;
	endproperty
	a_start: assert property (p_start) else $error("fetch start ignored");
	property p_sel_start;
		wa && sfr_wdata_in[7] && sfr_wdata_in[5:2] == 4'h8 && !busy_out
			|-> ##[1:2] (fifo_rd_out && fifo_sel_out == sel_q[1:0]);
	endproperty
	a_sel_start: assert property (p_sel_start) else $error("fetch used old selection");
	property p_busy_len;
		$rose(busy_out) |-> ##1 busy_out ##1 !busy_out;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_auto;
		rdd && auto_q |-> ##[1:2] busy_out;
	endproperty
	a_auto: assert property (p_auto) else $error("auto fetch missing");
	property p_no_auto;
		rdd && !auto_q && !wa |-> ##1 !busy_out;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("fetch without request");
	property p_fadr;
		wd && sel_q == 6'h00 |=> function_address_out == $past(sfr_wdata_in[6:0]);
	endproperty
	a_fadr: assert property (p_fadr) else $error("function address not written");
	property p_epsel;
		wd && sel_q == 6'h0e |=> endpoint_select_out == $past(sfr_wdata_in[3:0]);
	endproperty
	a_epsel: assert property (p_epsel) else $error("endpoint select not written");
	property p_inen;
		wd && sel_q == 6'h07 |=> in_endpoint_irq_enables_out == $past(sfr_wdata_in);
	endproperty
	a_inen: assert property (p_inen) else $error("irq enable not written");
	property p_same_sel;
		wd && sel_q == 6'h0f |=> clock_recovery_control_out == $past(sfr_wdata_in);
	endproperty
	a_same_sel: assert property (p_same_sel) else $error("repeat write lost");
	property p_unmapped;
		wd && sel_q == 6'h03 |=> $stable(function_address_out)
			&& $stable(power_management_out) && $stable(clock_recovery_control_out);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write took effect");
endmodule

bind usbip_top usbip_top_asserts #(.EP_COUNT(EP_COUNT)) u_chk (.core_clk_in, .rst_in,
	.sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .function_address_out,
	.power_management_out, .in_endpoint_irq_enables_out, .endpoint_select_out,
	.clock_recovery_control_out, .fifo_rd_out, .fifo_sel_out, .busy_out);

// ==== test/usbip_cpu_model.sv ====
// processor-side model issuing sfr accesses to the port
module usbip_cpu_model
(
	input wire logic core_clk_in,
	input wire logic busy_in,
	output logic [7:0] sfr_addr_out,
	output logic [7:0] sfr_wdata_out,
	output logic sfr_wr_out,
	output logic sfr_rd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
		{sfr_addr_out, sfr_wdata_out, sfr_wr_out, sfr_rd_out} = 18'h00000;
	// core clock never stops, so every access is clocked through
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_in);
		sfr_addr_out = a;
		sfr_wdata_out = d;
		sfr_wr_out = wr;
		sfr_rd_out = !wr;
		@(negedge core_clk_in);
		sfr_wr_out = 1'b0;
		sfr_rd_out = 1'b0;
		// released lines show junk so stale values cannot pass
		sfr_addr_out = ~a;
		sfr_wdata_out = ~d;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(negedge core_clk_in);
		while (busy_in !== 1'b0 && n < 50)
		begin
			@(negedge core_clk_in);
			n++;
		end
	endtask
endmodule

// ==== test/usbip_top_tb_top.sv ====
// self-checking bench for the indirect usb register port
module usbip_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, clock_recovery_control_out;
	logic sfr_wr_in, sfr_rd_in, busy_out, rd_seen;
	logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] live [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] regs [8] = '{8'h00, 8'h01, 8'h07, 8'h09, 8'h0b, 8'h0e, 8'h0f, 8'h1e};
	logic [7:0] msk [8] = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
	logic [7:0] lsel [4] = '{8'h0c, 8'h0d, 8'h16, 8'h17};
	logic [7:0] fifo_d = 8'h00;
	logic [7:0] fl [3];
	logic [7:0] wv [8];
	logic [7:0] pm_o, oen_o, cen_o, een_o, fifo_wdata_out;
	logic [1:0] fifo_sel_out;
	logic fifo_wr_out;
	logic [7:0] v;
	logic [7:0] exp_q [$];
	logic [15:0] rnd = 16'h3e7d;
	int fails = 0;
	int checks = 0;
	always #10 core_clk_in = ~core_clk_in;
	usbip_cpu_model i_cpu (.core_clk_in, .busy_in(busy_out), .sfr_addr_out(sfr_addr_in),
		.sfr_wdata_out(sfr_wdata_in), .sfr_wr_out(sfr_wr_in), .sfr_rd_out(sfr_rd_in));
	usbip_top #(.EP_COUNT(4), .EP_AW(2)) i_dut (.core_clk_in, .rst_in, .sfr_addr_in,
		.sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .in_irq_event_in(ev[0]),
		.out_irq_event_in(ev[1]), .common_irq_event_in(ev[2]),
		.frame_number_low_in(live[0]), .frame_number_high_in(live[1]),
		.endpoint0_rx_count_in(live[2]), .out_packet_count_high_in(live[3]),
		.fifo_rdata_in(fifo_d), .function_address_out(), .power_management_out(pm_o),
		.in_endpoint_irq_enables_out(), .out_endpoint_irq_enables_out(oen_o),
		.common_irq_enables_out(cen_o), .endpoint_select_out(), .clock_recovery_control_out,
		.endpoint_enable_out(een_o), .in_endpoint_irq_flags_out(fl[0]),
		.out_endpoint_irq_flags_out(fl[1]), .common_irq_flags_out(fl[2]), .fifo_wr_out,
		.fifo_rd_out(), .fifo_sel_out, .fifo_wdata_out, .busy_out);
	function automatic logic [7:0] nr();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd[7:0];
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] e);
		checks++;
		if (seen !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] sel, input logic [7:0] d);
		i_cpu.access(1'b1, 8'h96, sel);
		i_cpu.access(1'b1, 8'h97, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_cpu.access(1'b0, a, 8'h00);
	endtask
	task automatic fetch(input logic [7:0] sel, input logic [7:0] e);
		i_cpu.access(1'b1, 8'h96, sel | 8'h80);
		i_cpu.wait_idle();
		check("busy", {7'h00, busy_out}, 8'h00);
		rd(8'h97, e);
	endtask
	// read data is registered, so it is judged one edge after the strobe
	always @(posedge core_clk_in)
		rd_seen <= sfr_rd_in && !rst_in;
	always @(negedge core_clk_in)
		if (rd_seen && exp_q.size() > 0)
			check("read data", sfr_rdata_out, exp_q.pop_front());
	initial
	begin
		#100us;
		fails++;
		close_out();
	end
	initial
	begin
		repeat (2) @(posedge core_clk_in);
		@(negedge core_clk_in);
		rst_in = 1'b0;
		rd(8'h97, 8'h00);
		i_cpu.access(1'b1, 8'h96, 8'h8f);
		rd(8'h96, 8'h8f);
		i_cpu.wait_idle();
		rd(8'h96, 8'h0f);
		rd(8'h97, 8'h0f);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			v = nr();
			wr(regs[i], v);
			wv[i] = v & msk[i];
			fetch(regs[i], wv[i]);
		end
		check("power", pm_o, wv[1]);
		check("out enables", oen_o, wv[3]);
		check("common enables", cen_o, wv[4]);
		check("endpoint enable", een_o, wv[7]);
		wr(8'h0f, 8'h3c);
		i_cpu.access(1'b1, 8'h97, 8'h5a);
		check("repeat write", clock_recovery_control_out, 8'h5a);
		wr(8'h03, 8'ha5);
		fetch(8'h03, 8'h00);
		rd(8'h90, 8'h00);
		$display("test writes done");
		for (int i = 0; i < 4; i++)
		begin
			live[i] = nr();
			fetch(lsel[i], live[i]);
		end
		live[0] = nr();
		fetch(8'h0c, live[0]);
		i_cpu.access(1'b1, 8'h96, 8'hcc);
		i_cpu.wait_idle();
		rd(8'h97, live[0]);
		live[0] = nr();
		i_cpu.wait_idle();
		i_cpu.access(1'b1, 8'h96, 8'h0c);
		rd(8'h97, live[0]);
		$display("test reads done");
		for (int i = 0; i < 3; i++)
		begin
			v = nr();
			@(negedge core_clk_in);
			ev[i] = v;
			@(negedge core_clk_in);
			ev[i] = 8'h00;
			check("flag pins", fl[i], v);
			fetch(8'h02 + 8'(2 * i), v);
			fetch(8'h02 + 8'(2 * i), 8'h00);
		end
		$display("test flags done");
		for (int i = 1; i < 3; i++)
		begin
			wr(8'h0e, 8'(i));
			wr(8'h14, 8'(i * 17));
			wr(8'h15, 8'(i * 3));
		end
		for (int i = 1; i < 3; i++)
		begin
			wr(8'h0e, 8'(i));
			fetch(8'h14, 8'(i * 17));
			fetch(8'h15, 8'(i * 3));
		end
		wr(8'h0e, 8'h05);
		wr(8'h14, 8'hff);
		fetch(8'h14, 8'h00);
		wr(8'h0e, 8'h01);
		fetch(8'h14, 8'h11);
		fifo_d = nr();
		fetch(8'h21, fifo_d);
		v = nr();
		wr(8'h22, v);
		check("fifo strobe", {5'h00, fifo_wr_out, fifo_sel_out}, 8'h06);
		check("fifo data", fifo_wdata_out, v);
		$display("test indexed done");
		repeat (4) @(negedge core_clk_in);
		close_out();
	end
endmodule
